// File: design/cmt_pkg.sv
// Behaviour
// - A 32-bit timer counter advances from a programmable 32-bit prescale counter, both on the counting clock.
// - Up to four 32-bit capture channels store the timer count when their capture input changes state.
// - A capture raises an interrupt request only when enabled for that channel, otherwise it is silent.
// - Four 32-bit match registers are each compared against the timer count.
// - A match in continuous mode leaves the counter running and raises an interrupt if enabled.
// - A match configured to stop halts counting, optionally raising an interrupt.
// - A match configured to reset returns the timer count to zero unless a stop match in the same cycle holds it, optionally raising an interrupt.
// - Each match output goes low, high, toggles or holds on its match, as configured.
// - All counting, capture and match timing is in periods of the counting clock.
// - Configuration set from the bus side must be presented in the counting clock domain.
package cmt_pkg;
   // -------------------------------------------------------------
   // Sizes and reset values
   // -------------------------------------------------------------
   localparam int unsigned    CNT_W       = 32;
   localparam int unsigned    NUM_CH      = 4;
   localparam int unsigned    SYNC_DEPTH  = 3;
   localparam logic [31:0]    COUNT_RST   = 32'h0000_0000;
   localparam logic           PIN_RST     = 1'b0;

   // -------------------------------------------------------------
   // Match output actions
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      CMT_ACT_NONE   = 2'h0,
      CMT_ACT_LOW    = 2'h1,
      CMT_ACT_HIGH   = 2'h2,
      CMT_ACT_TOGGLE = 2'h3
   } cmt_action_t;
endpackage : cmt_pkg

// File: design/cmt_cap_if.sv
`timescale 1ns/10ps
// Carries the count to the capture bank and its results back
interface cmt_cap_if #(
   parameter int unsigned WIDTH    = 32,
   parameter int unsigned CHANNELS = 4
);
   logic [WIDTH-1:0]                count;     // Live timer count
   logic [CHANNELS-1:0]             rise_en;   // Capture on rising change
   logic [CHANNELS-1:0]             fall_en;   // Capture on falling change
   logic [CHANNELS-1:0]             event_p;   // Capture happened, pulse
   logic [CHANNELS-1:0][WIDTH-1:0]  value;     // Captured counts

   modport timer (output count, rise_en, fall_en, input event_p, value);
   modport bank  (input count, rise_en, fall_en, output event_p, value);
endinterface : cmt_cap_if

// File: design/cmt_capture_bank.sv
`timescale 1ns/10ps
module cmt_capture_bank #(
   parameter int unsigned WIDTH    = cmt_pkg::CNT_W,
   parameter int unsigned CHANNELS = cmt_pkg::NUM_CH
) (
   input  wire logic                clock_i,    // Counting clock
   input  wire logic                rst_n_i,    // Async reset, low
   input  wire logic [CHANNELS-1:0] pin_i,      // Raw capture inputs
   cmt_cap_if.bank                  cap         // Link to the timer
);
   // -------------------------------------------------------------
   // One synchroniser, change detector and capture register per pin
   // -------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         logic [cmt_pkg::SYNC_DEPTH-1:0] sync_q, sync_d;
         logic                           level_q, level_d;
         logic                           evt_q, evt_d;
         logic [WIDTH-1:0]               val_q, val_d;

         // Change counts once stages two and three agree
         always_comb begin
            sync_d  = {sync_q[cmt_pkg::SYNC_DEPTH-2:0], pin_i[g]};
            level_d = level_q;
            evt_d   = 1'b0;
            val_d   = val_q;
            if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
               level_d = sync_q[2];
               if ((sync_q[2] && cap.rise_en[g]) ||
                   (!sync_q[2] && cap.fall_en[g])) begin
                  evt_d = 1'b1;
                  val_d = cap.count;
               end
            end
         end

         // Register channel state
         always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync_q  <= '0;
               level_q <= 1'b0;
               evt_q   <= 1'b0;
               val_q   <= '0;
            end else begin
               sync_q  <= sync_d;
               level_q <= level_d;
               evt_q   <= evt_d;
               val_q   <= val_d;
            end
         end

         assign cap.event_p[g] = evt_q;
         assign cap.value[g]   = val_q;
      end
   endgenerate
endmodule : cmt_capture_bank

// File: design/cmt_timer.sv
`timescale 1ns/10ps
module cmt_timer #(
   parameter int unsigned WIDTH    = cmt_pkg::CNT_W,
   parameter int unsigned CHANNELS = cmt_pkg::NUM_CH
) (
   input  wire logic                             clock_i,          // Counting clock
   input  wire logic                             rst_n_i,          // Async reset, low
   input  wire logic                             timer_enable_i,   // Run request
   input  wire logic                             counter_clear_i,  // Zero both counters
   input  wire logic [WIDTH-1:0]                 prescale_limit_i, // Prescale wrap value
   input  wire logic [CHANNELS-1:0][WIDTH-1:0]   match_value_i,    // Match registers
   input  wire logic [CHANNELS-1:0]              match_irq_en_i,   // Irq on match
   input  wire logic [CHANNELS-1:0]              match_stop_en_i,  // Stop on match
   input  wire logic [CHANNELS-1:0]              match_reset_en_i, // Reset on match
   input  wire logic [CHANNELS-1:0][1:0]         match_action_i,   // Output action
   input  wire logic [CHANNELS-1:0]              capture_input_i,  // Capture pins
   input  wire logic [CHANNELS-1:0]              capture_rise_en_i,// Capture on rise
   input  wire logic [CHANNELS-1:0]              capture_fall_en_i,// Capture on fall
   input  wire logic [CHANNELS-1:0]              capture_irq_en_i, // Irq on capture
   output logic      [WIDTH-1:0]                 timer_count_o,    // Timer count
   output logic      [WIDTH-1:0]                 prescale_count_o, // Prescale count
   output logic                                  timer_running_o,  // Counting now
   output logic      [CHANNELS-1:0]              match_output_o,   // Match pins
   output logic      [CHANNELS-1:0]              match_irq_o,      // Match irq pulse
   output logic      [CHANNELS-1:0]              capture_irq_o,    // Capture irq pulse
   output logic      [CHANNELS-1:0][WIDTH-1:0]   capture_value_o   // Captured counts
);
   // -------------------------------------------------------------
   // Parameter check
   // -------------------------------------------------------------
   if (CHANNELS < 1 || CHANNELS > cmt_pkg::NUM_CH || WIDTH < 2) begin : g_chk
      $error("cmt_timer: unsupported CHANNELS or WIDTH");
   end

   // -------------------------------------------------------------
   // Counter state
   // -------------------------------------------------------------
   logic [WIDTH-1:0]    pc_q, pc_d;
   logic [WIDTH-1:0]    tc_q, tc_d;
   logic                stop_q, stop_d;
   logic [CHANNELS-1:0] mat_q, mat_d;
   logic [CHANNELS-1:0] mirq_q, mirq_d;
   logic [CHANNELS-1:0] cirq_q, cirq_d;
   logic                run;
   logic                tick;
   logic [CHANNELS-1:0] hit;

   cmt_cap_if #(.WIDTH(WIDTH), .CHANNELS(CHANNELS)) cap ();

   // Configuration is used as seen on the counting clock
   assign run  = timer_enable_i && !stop_q;
   assign tick = run && (pc_q == prescale_limit_i);

   // Match compare per channel, acted on at the count's tick
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_cmp
         assign hit[g] = tick && (tc_q == match_value_i[g]);
      end
   endgenerate

   // Next values of counters, stop latch, pins and requests
   always_comb begin
      pc_d   = pc_q;
      tc_d   = tc_q;
      stop_d = stop_q;
      mat_d  = mat_q;
      mirq_d = hit & match_irq_en_i;
      cirq_d = cap.event_p & capture_irq_en_i;
      if (!timer_enable_i) begin
         stop_d = 1'b0;
      end
      if (run) begin
         pc_d = tick ? '0 : pc_q + 1'b1;
         if (tick) begin
            tc_d = tc_q + 1'b1;
         end
      end
      if (|(hit & match_reset_en_i)) begin
         tc_d = '0;
      end
      if (|(hit & match_stop_en_i)) begin
         stop_d = 1'b1;
         tc_d   = tc_q;
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (hit[i]) begin
            case (cmt_pkg::cmt_action_t'(match_action_i[i]))
               cmt_pkg::CMT_ACT_NONE:   mat_d[i] = mat_q[i];
               cmt_pkg::CMT_ACT_LOW:    mat_d[i] = 1'b0;
               cmt_pkg::CMT_ACT_HIGH:   mat_d[i] = 1'b1;
               cmt_pkg::CMT_ACT_TOGGLE: mat_d[i] = !mat_q[i];
               default:                 mat_d[i] = mat_q[i];
            endcase
         end
      end
      if (counter_clear_i) begin
         pc_d = '0;
         tc_d = '0;
      end
   end

   // Register counter state
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_q   <= cmt_pkg::COUNT_RST[WIDTH-1:0];
         tc_q   <= cmt_pkg::COUNT_RST[WIDTH-1:0];
         stop_q <= 1'b0;
         mat_q  <= {CHANNELS{cmt_pkg::PIN_RST}};
         mirq_q <= '0;
         cirq_q <= '0;
      end else begin
         pc_q   <= pc_d;
         tc_q   <= tc_d;
         stop_q <= stop_d;
         mat_q  <= mat_d;
         mirq_q <= mirq_d;
         cirq_q <= cirq_d;
      end
   end

   // -------------------------------------------------------------
   // Capture bank
   // -------------------------------------------------------------
   assign cap.count   = tc_q;
   assign cap.rise_en = capture_rise_en_i;
   assign cap.fall_en = capture_fall_en_i;

   cmt_capture_bank #(
      .WIDTH    (WIDTH),
      .CHANNELS (CHANNELS)
   ) u_cap (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .pin_i   (capture_input_i),
      .cap     (cap.bank)
   );

   // Outputs
   assign timer_count_o    = tc_q;
   assign prescale_count_o = pc_q;
   assign timer_running_o  = run;
   assign match_output_o   = mat_q;
   assign match_irq_o      = mirq_q;
   assign capture_irq_o    = cirq_q;
   assign capture_value_o  = cap.value;
endmodule : cmt_timer

// File: test/cmt_cap_src.sv
`timescale 1ns/10ps
// Far-side source of the capture pins, free of the counting clock
module cmt_cap_src (
   input  wire logic [3:0]  level_i, // Wanted levels
   input  wire logic [31:0] lag_i,   // Lag in ns
   output logic      [3:0]  pin_o    // Capture pins
);
   initial pin_o = 4'h0;
   // Pins follow the wanted level after a slow or prompt lag
   always @(level_i) pin_o <= #(lag_i) level_i;
endmodule : cmt_cap_src

// File: test/cmt_timer_chk.sv
`timescale 1ns/10ps
module cmt_timer_chk #(
   parameter int unsigned WIDTH    = 32,
   parameter int unsigned CHANNELS = 4
) (
   input wire logic                          clock_i,          // Clock
   input wire logic                          rst_n_i,          // Reset
   input wire logic                          counter_clear_i,  // Clear
   input wire logic [WIDTH-1:0]              prescale_limit_i, // Limit
   input wire logic [CHANNELS-1:0][WIDTH-1:0] match_value_i,   // Match
   input wire logic [CHANNELS-1:0]           match_irq_en_i,   // Irq en
   input wire logic [CHANNELS-1:0]           match_stop_en_i,  // Stop en
   input wire logic [CHANNELS-1:0]           match_reset_en_i, // Reset en
   input wire logic [CHANNELS-1:0][1:0]      match_action_i,   // Action
   input wire logic [WIDTH-1:0]              timer_count_o,    // Count
   input wire logic [WIDTH-1:0]              prescale_count_o, // Prescale
   input wire logic                          timer_running_o,  // Running
   input wire logic [CHANNELS-1:0]           match_output_o,   // Pins
   input wire logic [CHANNELS-1:0]           match_irq_o       // Irq
);
   logic                tick;  // Prescale wraps now
   logic [CHANNELS-1:0] hit;   // Channels that match now
   logic [CHANNELS-1:0] pin_d; // Pins after this edge
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Expected tick, hits and pin levels
   always_comb begin
      tick = timer_running_o && !counter_clear_i
             && prescale_count_o == prescale_limit_i;
      for (int i = 0; i < CHANNELS; i++) begin
         hit[i] = tick && timer_count_o == match_value_i[i];
         pin_d[i] = !hit[i] ? match_output_o[i]
                  : match_action_i[i] == 2'h3 ? !match_output_o[i]
                  : match_action_i[i] == 2'h0 ? match_output_o[i]
                  : match_action_i[i][1];
      end
   end
   a_pc_wrap: assert property (tick |=> prescale_count_o == '0)
      else $error("prescale did not wrap");
   a_pc_step: assert property (timer_running_o && !counter_clear_i && !tick
      |=> prescale_count_o == $past(prescale_count_o) + 1'b1)
      else $error("prescale did not step");
   a_tc_step: assert property (tick && (hit & (match_stop_en_i |
      match_reset_en_i)) == '0 |=> timer_count_o == $past(timer_count_o) + 1'b1)
      else $error("count did not step");
   a_hold_idle: assert property (!timer_running_o && !counter_clear_i
      |=> $stable(timer_count_o) && $stable(prescale_count_o))
      else $error("counts moved while idle");
   a_reset_zero: assert property ((hit & match_reset_en_i) != '0
      && (hit & match_stop_en_i) == '0 |=> timer_count_o == '0)
      else $error("count not zeroed on match");
   a_stop_halt: assert property ((hit & match_stop_en_i) != '0
      |=> !timer_running_o && timer_count_o == $past(timer_count_o))
      else $error("timer did not stop on match");
   a_irq_cause: assert property (1'b1
      |=> match_irq_o == $past(hit & match_irq_en_i))
      else $error("match irq wrong");
   a_pin_act: assert property (1'b1 |=> match_output_o == $past(pin_d))
      else $error("match pin wrong");
endmodule : cmt_timer_chk
bind cmt_timer cmt_timer_chk #(.WIDTH(WIDTH), .CHANNELS(CHANNELS)) chk_i (
   .clock_i, .rst_n_i, .counter_clear_i, .prescale_limit_i, .match_value_i,
   .match_irq_en_i, .match_stop_en_i, .match_reset_en_i, .match_action_i,
   .timer_count_o, .prescale_count_o, .timer_running_o, .match_output_o,
   .match_irq_o);

// File: test/test_capture_match_timer.sv
`timescale 1ns/10ps
module test_capture_match_timer;
   logic             clock_i = 1'b0, rst_n_i = 1'b0, en = 1'b0, clr = 1'b0;
   logic [31:0]      lim = '0, tc, pc;
   logic [3:0][31:0] mv = '0, cval;
   logic [3:0][1:0]  act = '0;
   logic [3:0]       mirq_en = '0, stop_en = '0, rst_en = '0, lvl = '0;
   logic [3:0]       rise = '0, fall = '0, cirq_en = '0, cap, pins, mirq, cirq;
   logic             run;
   logic [35:0]      mq[$], cq[$];
   int               n_fail = 0, comparisons = 0, seed = 57;
   int unsigned      lag = 0, lr;
   always #25 clock_i = ~clock_i;
   cmt_cap_src cmt_cap_src_i (.level_i(lvl), .lag_i(lag), .pin_o(cap));
   cmt_timer cmt_timer_i (.clock_i, .rst_n_i, .timer_enable_i(en),
      .counter_clear_i(clr), .prescale_limit_i(lim), .match_value_i(mv),
      .match_irq_en_i(mirq_en), .match_stop_en_i(stop_en),
      .match_reset_en_i(rst_en), .match_action_i(act), .capture_input_i(cap),
      .capture_rise_en_i(rise), .capture_fall_en_i(fall),
      .capture_irq_en_i(cirq_en), .timer_count_o(tc), .prescale_count_o(pc),
      .timer_running_o(run), .match_output_o(pins), .match_irq_o(mirq),
      .capture_irq_o(cirq), .capture_value_o(cval));
   task automatic check(input logic [35:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic wait_q;
      for (int i = 0; i < 200 && mq.size() + cq.size() > 0; i++)
         @(posedge clock_i);
      #1 check(36'(mq.size() + cq.size()), '0);
   endtask : wait_q
   // Takes the oldest note whenever an irq pulse shows
   always begin
      logic [35:0] n;
      @(posedge clock_i);
      #1;
      if (mirq !== 4'h0) check({mirq, 32'(pins)}, mq.size() ?
         mq.pop_front() : 36'hF_FFFF_FFFF);
      if (cirq !== 4'h0) begin
         n = cq.size() ? cq.pop_front() : 36'hF_FFFF_FFFF;
         for (int i = 0; i < 4; i++)
            if (cirq[i] !== 1'b0) check({cirq, cval[i]}, n);
      end
   end
   // Cuts a hang short
   initial begin
      #(3000 * 50);
      n_fail++;
      print_verdict();
   end
   // Main sequence
   initial begin
      lr = $unsigned($random(seed)) % 3;
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      lim <= lr;
      en <= 1'b1;
      repeat (10 * (lr + 1)) @(posedge clock_i);
      #1 check(36'(tc), 36'(10));
      $display("count test done");
      @(posedge clock_i);
      en <= 1'b0;
      clr <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         mv[i] <= 32'(i == 0 ? 5 : i + 1);
         act[i] <= 2'(i);
      end
      {mirq_en, stop_en, rst_en} <= 12'hF_11;
      mq = '{36'h2_0000_0000, 36'h4_0000_0004, 36'h8_0000_000C, 36'h1_0000_000C};
      @(posedge clock_i);
      clr <= 1'b0;
      en <= 1'b1;
      wait_q();
      check({3'h0, run, tc}, 36'h0_0000_0005);
      $display("match stop test done");
      @(posedge clock_i);
      en <= 1'b0;
      {mirq_en, stop_en} <= 8'h00;
      @(posedge clock_i);
      en <= 1'b1;
      repeat (8 * (lr + 1)) @(posedge clock_i);
      #1 check(36'(tc), 36'(1));
      $display("match reset test done");
      @(posedge clock_i);
      {en, clr, rst_en, lim} <= {2'h1, 4'h0, 32'h0000_0000};
      {rise, fall, cirq_en} <= 12'hF_57;
      @(posedge clock_i);
      {en, clr} <= 2'h2;
      repeat (20) @(posedge clock_i);
      en <= 1'b0;
      lag = $unsigned($random(seed)) % 50;
      cq.push_back({4'h7, 32'(20)});
      lvl <= 4'hF;
      wait_q();
      @(posedge clock_i);
      en <= 1'b1;
      repeat (5) @(posedge clock_i);
      en <= 1'b0;
      lag = $unsigned($random(seed)) % 50;
      cq.push_back({4'h5, 32'(25)});
      lvl <= 4'h0;
      wait_q();
      check({cval[3], cval[1][3:0]}, {32'(20), 4'h4});
      $display("capture test done");
      print_verdict();
   end
endmodule : test_capture_match_timer
